// ==== verilog/dbha_pkg.sv ====
// Overview of operation
// - window aligned on four-byte boundary
// - match A7..A2 and expansion select
// - fitted strap demands zero, open one
// - four consecutive addresses inside window
// - offsets: data, control/status, two setups
// - data port passes byte to bus
// - status port bit order reset..direction
// - status lines in, control lines out
// - auto acknowledge after each data access
// - auto acknowledge only with strap fitted
// - ready rises when request falls
// - data port read clears ready
// - polled or vectored interrupts via setup
package dbha_pkg;
   // ---------------------------------------------------------------
   // register offsets (A1:A0)
   // ---------------------------------------------------------------
   localparam logic [1:0] OFF_DATA_BYTE = 2'h0;
   localparam logic [1:0] OFF_BUS_CTL_STAT = 2'h1;
   localparam logic [1:0] OFF_DATA_SETUP = 2'h2;
   localparam logic [1:0] OFF_CTL_SETUP = 2'h3;
   // ---------------------------------------------------------------
   // status/control port bit positions
   // ---------------------------------------------------------------
   localparam int BIT_BUS_RESET = 7;
   localparam int BIT_SELECT = 6;
   localparam int BIT_ACK = 5;
   localparam int BIT_BUSY = 4;
   localparam int BIT_MSG = 3;
   localparam int BIT_CD = 2;
   localparam int BIT_REQ = 1;
   localparam int BIT_IO = 0;
   localparam int WIN_LSB = 2;
   localparam int STRAP_W = 7;
   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [2:0] CTL_LINES_RESET = 3'h7;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [7:0] VECTOR_RESET = 8'h00;
   localparam logic [1:0] MODE_RESET = 2'h2;
   localparam logic [7:0] SETUP_READ_VALUE = 8'h00;
   // ---------------------------------------------------------------
   // setup word decode
   // ---------------------------------------------------------------
   localparam logic [3:0] SETUP_MODE_CODE = 4'hf;
   localparam logic [3:0] SETUP_INTCTL_CODE = 4'h7;
   localparam logic [3:0] SETUP_INTEN_CODE = 4'h3;
   localparam int SETUP_INT_EN_BIT = 7;
   localparam logic [1:0] MODE_OUTPUT = 2'h0;
   localparam logic [1:0] MODE_INPUT = 2'h1;
   localparam logic [1:0] MODE_BIDIR = 2'h2;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 40;
   localparam int SYNC_STAGES = 2;

   typedef struct packed {
      logic bsy_n;
      logic msg_n;
      logic cd_n;
      logic req_n;
      logic io_n;
   } dbha_status_t;

   typedef struct packed {
      logic rst_n;
      logic sel_n;
      logic ack_n;
   } dbha_ctl_t;
endpackage : dbha_pkg

// ==== verilog/dbha_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module dbha_sync #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   // ---------------------------------------------------------------
   // two-stage synchroniser per bit
   // ---------------------------------------------------------------
   if (WIDTH < 1) begin : g_bad_width
      $error("dbha_sync: WIDTH must be positive");
   end
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic meta_reg;
         logic stab_reg;
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               meta_reg <= 1'b0;
               stab_reg <= 1'b0;
            end else begin
               meta_reg <= async_in[i];
               stab_reg <= meta_reg;
            end
         end
         assign sync_out[i] = stab_reg;
      end
   endgenerate
endmodule : dbha_sync
`default_nettype wire

// ==== verilog/dbha_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module dbha_top
   import dbha_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] bp_addr,
   input wire logic io_expansion_select,
   input wire logic bp_rd,
   input wire logic bp_wr,
   input wire logic bp_int_ack,
   input wire logic [7:0] bp_data_in,
   output logic [7:0] bp_data_out,
   output logic bp_data_oe,
   output logic bp_int_req,
   input wire logic [STRAP_W-1:0] address_strap_header,
   input wire logic auto_acknowledge_strap,
   output logic external_ready_connector,
   input wire logic [7:0] db_in,
   output logic [7:0] db_out,
   output logic db_oe,
   input wire dbha_status_t periph_status,
   output dbha_ctl_t periph_ctl
);
   // ---------------------------------------------------------------
   // synchronise every pin input except clk and sys_rst
   // ---------------------------------------------------------------
   localparam int SYNC_W = 8 + 1 + 1 + 1 + 1 + 8 + STRAP_W + 1 + 8 + 5;
   logic [SYNC_W-1:0] sync_out;
   logic [7:0] addr_s;
   logic iox_s;
   logic rd_s;
   logic wr_s;
   logic intack_s;
   logic [7:0] wdata_s;
   logic [STRAP_W-1:0] strap_s;
   logic strap_auto_s;
   logic [7:0] db_s;
   dbha_status_t stat_s;

   dbha_sync #(.WIDTH(SYNC_W)) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .async_in({bp_addr, io_expansion_select, bp_rd, bp_wr, bp_int_ack, bp_data_in,
                 address_strap_header, auto_acknowledge_strap, db_in, periph_status}),
      .sync_out(sync_out)
   );
   assign {addr_s, iox_s, rd_s, wr_s, intack_s, wdata_s, strap_s, strap_auto_s, db_s, stat_s} = sync_out;

   // ---------------------------------------------------------------
   // window decode and strobe edges
   // ---------------------------------------------------------------
   logic rd_d_reg;
   logic wr_d_reg;
   logic intack_d_reg;
   logic req_d_reg;
   wire [1:0] off = addr_s[1:0];
   wire hit = ({iox_s, addr_s[7:WIN_LSB]} == ~strap_s);
   wire rd_pulse = rd_s & ~rd_d_reg & hit;
   wire wr_pulse = wr_s & ~wr_d_reg & hit;
   wire data_rd = rd_pulse & (off == OFF_DATA_BYTE);
   wire data_wr = wr_pulse & (off == OFF_DATA_BYTE);
   wire ctl_wr = wr_pulse & (off == OFF_BUS_CTL_STAT);
   wire setup_a_wr = wr_pulse & (off == OFF_DATA_SETUP);
   // port b direction is fixed, its setup writes are absorbed
   wire req_fall = req_d_reg & ~stat_s.req_n;
   wire intack_rise = intack_s & ~intack_d_reg;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_d_reg <= 1'b0;
         wr_d_reg <= 1'b0;
         intack_d_reg <= 1'b0;
         // same level as the synchroniser reset, so no false fall
         req_d_reg <= 1'b0;
      end else begin
         rd_d_reg <= rd_s;
         wr_d_reg <= wr_s;
         intack_d_reg <= intack_s;
         req_d_reg <= stat_s.req_n;
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [7:0] data_out_reg;
   logic [2:0] ctl_lines_reg;
   logic [1:0] mode_a_reg;
   logic [7:0] vector_reg;
   logic int_en_reg;
   logic ready_reg;
   logic ack_auto_reg;
   logic irq_reg;
   logic [7:0] rdata_reg;
   logic vec_drive_reg;

   wire [7:0] ctl_stat_view = {periph_ctl.rst_n, periph_ctl.sel_n, periph_ctl.ack_n, stat_s.bsy_n,
                               stat_s.msg_n, stat_s.cd_n, stat_s.req_n, stat_s.io_n};
   wire [7:0] rd_mux = (off == OFF_DATA_BYTE) ? db_s :
                       (off == OFF_BUS_CTL_STAT) ? ctl_stat_view : SETUP_READ_VALUE;
   wire is_vec = ~wdata_s[0];
   wire is_mode = (wdata_s[3:0] == SETUP_MODE_CODE);
   wire is_inten = (wdata_s[3:0] == SETUP_INTCTL_CODE) | (wdata_s[3:0] == SETUP_INTEN_CODE);
   wire ack_set = (data_rd | data_wr) & strap_auto_s;
   wire ack_clr = ack_auto_reg & stat_s.req_n;
   wire ready_next = req_fall | (ready_reg & ~data_rd);
   wire irq_next = (req_fall & int_en_reg) | (irq_reg & ~intack_rise);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         data_out_reg <= BYTE_RESET;
         ctl_lines_reg <= CTL_LINES_RESET;
      end else begin
         if (data_wr) data_out_reg <= wdata_s;
         if (ctl_wr) ctl_lines_reg <= wdata_s[BIT_BUS_RESET:BIT_ACK];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mode_a_reg <= MODE_RESET;
         vector_reg <= VECTOR_RESET;
         int_en_reg <= 1'b0;
      end else begin
         if (setup_a_wr & is_vec) vector_reg <= wdata_s;
         if (setup_a_wr & ~is_vec & is_mode) mode_a_reg <= wdata_s[7:6];
         if (setup_a_wr & ~is_vec & is_inten) int_en_reg <= wdata_s[SETUP_INT_EN_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ready_reg <= 1'b0;
         ack_auto_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         ready_reg <= ready_next;
         ack_auto_reg <= ack_set | (ack_auto_reg & ~ack_clr);
         irq_reg <= irq_next;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_reg <= BYTE_RESET;
         vec_drive_reg <= 1'b0;
      end else begin
         if (intack_rise & irq_reg) rdata_reg <= vector_reg;
         else if (rd_pulse) rdata_reg <= rd_mux;
         if (intack_rise) vec_drive_reg <= irq_reg;
         else if (~intack_s) vec_drive_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // pin drive
   // ---------------------------------------------------------------
   assign bp_data_out = rdata_reg;
   assign bp_data_oe = (rd_s & rd_d_reg & hit) | vec_drive_reg;
   assign bp_int_req = irq_reg;
   assign external_ready_connector = ready_reg;
   assign db_out = data_out_reg;
   assign db_oe = (mode_a_reg == MODE_OUTPUT) | ((mode_a_reg == MODE_BIDIR) & stat_s.io_n);
   assign periph_ctl = '{rst_n: ctl_lines_reg[2], sel_n: ctl_lines_reg[1],
                         ack_n: ctl_lines_reg[0] & ~ack_auto_reg};

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_outside_window;
      @(posedge clk) disable iff (sys_rst)
      (wr_s & ~wr_d_reg & ~hit) |=> $stable(data_out_reg) && $stable(ctl_lines_reg);
   endproperty
   a_outside_window: assert property (p_outside_window) else $error("write outside window took effect");

   property p_data_write;
      @(posedge clk) disable iff (sys_rst)
      data_wr |=> (db_out == $past(wdata_s));
   endproperty
   a_data_write: assert property (p_data_write) else $error("data byte not placed on bus");

   property p_ctl_write;
      @(posedge clk) disable iff (sys_rst)
      ctl_wr |=> (ctl_lines_reg == $past(wdata_s[7:5]));
   endproperty
   a_ctl_write: assert property (p_ctl_write) else $error("control lines not loaded");

   property p_data_read;
      @(posedge clk) disable iff (sys_rst)
      data_rd |=> (bp_data_out == $past(db_s));
   endproperty
   a_data_read: assert property (p_data_read) else $error("data read returned wrong byte");

   property p_auto_ack;
      @(posedge clk) disable iff (sys_rst)
      ((data_rd | data_wr) & strap_auto_s) |=> !periph_ctl.ack_n;
   endproperty
   a_auto_ack: assert property (p_auto_ack) else $error("acknowledge not asserted after access");

   property p_ack_strap;
      @(posedge clk) disable iff (sys_rst)
      $rose(ack_auto_reg) |-> $past(strap_auto_s);
   endproperty
   a_ack_strap: assert property (p_ack_strap) else $error("auto acknowledge without strap");

   property p_ack_hold;
      @(posedge clk) disable iff (sys_rst)
      (ack_auto_reg & ~stat_s.req_n) |=> ack_auto_reg;
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("acknowledge dropped before request");

   property p_ack_release;
      @(posedge clk) disable iff (sys_rst)
      (ack_auto_reg & stat_s.req_n & ~ack_set) |=> !ack_auto_reg;
   endproperty
   a_ack_release: assert property (p_ack_release) else $error("acknowledge not released");

   property p_ready_set;
      @(posedge clk) disable iff (sys_rst)
      req_fall |=> external_ready_connector;
   endproperty
   a_ready_set: assert property (p_ready_set) else $error("ready missed request");

   property p_ready_clear;
      @(posedge clk) disable iff (sys_rst)
      (data_rd & ~req_fall) |=> !external_ready_connector;
   endproperty
   a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared by read");

   property p_vector_load;
      @(posedge clk) disable iff (sys_rst)
      (intack_rise & irq_reg) |=> (bp_data_out == $past(vector_reg)) && bp_data_oe && !bp_int_req;
   endproperty
   a_vector_load: assert property (p_vector_load) else $error("wrong vector returned");

   c_data_write: cover property (@(posedge clk) disable iff (sys_rst) data_wr ##1 !periph_ctl.ack_n);
   c_ready_cycle: cover property (@(posedge clk) disable iff (sys_rst) req_fall ##[1:50] data_rd);
   c_int_ack: cover property (@(posedge clk) disable iff (sys_rst) irq_reg ##[1:50] vec_drive_reg);
endmodule : dbha_top
`default_nettype wire

// ==== tb/dbha_periph_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// disk controller on the peripheral side
// ---------------------------------------------------------------
module dbha_periph_model
   import dbha_pkg::*;
(
   input wire logic clk,
   input wire logic [3:0] lines_n,
   input wire dbha_ctl_t periph_ctl,
   input wire logic [7:0] db_out,
   input wire logic db_oe,
   output dbha_status_t periph_status,
   output logic [7:0] db_in
);
   logic req_n_reg = 1'b1;
   logic sending = 1'b0;
   logic [7:0] idle_reg = 8'h00;
   logic [7:0] send_reg = 8'h00;
   // lines_n: busy, message, command/data, direction
   assign periph_status = {lines_n[3:1], req_n_reg, lines_n[0]};
   assign db_in = db_oe ? db_out : (sending ? send_reg : idle_reg);
   // undriven data lines change every cycle
   always @(negedge clk) begin
      idle_reg <= ~idle_reg;
   end
   task automatic send(input logic [7:0] d, input int hold, output logic ok);
      int n;
      n = 0;
      @(negedge clk);
      send_reg = d;
      sending = 1'b1;
      req_n_reg = 1'b0;
      @(negedge clk);
      while (periph_ctl.ack_n !== 1'b0 && n < 200) begin
         @(negedge clk);
         n++;
      end
      ok = (n < 200);
      repeat (hold) @(negedge clk);
      req_n_reg = 1'b1;
      sending = 1'b0;
   endtask : send
endmodule : dbha_periph_model
`default_nettype wire

// ==== tb/disk_bus_host_adapter_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module disk_bus_host_adapter_test
   import dbha_pkg::*;
;
   typedef struct packed {
      logic wr;
      logic [7:0] a;
      logic [7:0] d;
      logic [7:0] exp;
      logic [2:0] ctl;
   } dbha_row_t;
   logic clk = 1'b0, sys_rst = 1'b1, io_expansion_select = 1'b0, bp_rd = 1'b0, bp_wr = 1'b0, bp_int_ack = 1'b0;
   logic auto_acknowledge_strap = 1'b1, bp_data_oe, bp_int_req, external_ready_connector, db_oe;
   logic [7:0] bp_addr = 8'h00, bp_data_in = 8'h00, bp_data_out, db_in, db_out, q;
   logic oe_seen, ack_seen, ok;
   logic [3:0] lines_n = 4'b0100;
   dbha_status_t periph_status;
   dbha_ctl_t periph_ctl;
   int err_count = 0, compares = 0, cycles = 0, n;
   // window base 0x54, expansion select low
   dbha_row_t rows [0:7] = '{'{1'b1, 8'h54, 8'ha5, 8'ha5, 3'h7}, '{1'b1, 8'h54, 8'h5a, 8'h5a, 3'h7},
      '{1'b0, 8'h55, 8'h00, 8'hea, 3'h7}, '{1'b1, 8'h55, 8'h3f, 8'h5a, 3'h1},
      '{1'b0, 8'h55, 8'h00, 8'h2a, 3'h1}, '{1'b1, 8'h55, 8'he0, 8'h5a, 3'h7},
      '{1'b0, 8'h56, 8'h00, 8'h00, 3'h7}, '{1'b0, 8'h57, 8'h00, 8'h00, 3'h7}};

   always #12.5 clk = ~clk;

   dbha_top u_dbha_top (.clk(clk), .sys_rst(sys_rst), .bp_addr(bp_addr),
      .io_expansion_select(io_expansion_select), .bp_rd(bp_rd), .bp_wr(bp_wr), .bp_int_ack(bp_int_ack),
      .bp_data_in(bp_data_in), .bp_data_out(bp_data_out), .bp_data_oe(bp_data_oe),
      .bp_int_req(bp_int_req), .address_strap_header(7'h6a),
      .auto_acknowledge_strap(auto_acknowledge_strap), .external_ready_connector(external_ready_connector),
      .db_in(db_in), .db_out(db_out), .db_oe(db_oe), .periph_status(periph_status), .periph_ctl(periph_ctl));

   dbha_periph_model u_dbha_periph_model (.clk(clk), .lines_n(lines_n), .periph_ctl(periph_ctl),
      .db_out(db_out), .db_oe(db_oe), .periph_status(periph_status), .db_in(db_in));

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
         err_count++;
      end
   endtask : chk

   task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] rd);
      @(negedge clk);
      bp_addr = a;
      bp_data_in = d;
      bp_wr = wr;
      bp_rd = !wr;
      oe_seen = 1'b0;
      ack_seen = 1'b0;
      for (int i = 0; i < 10; i++) begin
         @(negedge clk);
         oe_seen |= bp_data_oe;
         ack_seen |= !periph_ctl.ack_n;
         if (i == 5) begin
            rd = bp_data_out;
            bp_rd = 1'b0;
            bp_wr = 1'b0;
         end
      end
   endtask : acc

   task end_sim;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_sim

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_count++;
         end_sim();
      end
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (6) @(negedge clk);
      sys_rst = 1'b0;
      chk("db_out", 8'h00, db_out);
      chk("ctl", 8'h07, {5'h0, periph_ctl});
      chk("ready", 8'h00, {7'h0, external_ready_connector});
      chk("bp_oe", 8'h00, {7'h0, bp_data_oe});
      foreach (rows[i]) begin
         acc(rows[i].wr, rows[i].a, rows[i].d, q);
         if (rows[i].wr) chk("db_out", rows[i].exp, db_out);
         else chk("rd_data", rows[i].exp, q);
         if (!rows[i].wr) chk("rd_oe", 8'h01, {7'h0, oe_seen});
         chk("ctl", {5'h0, rows[i].ctl}, {5'h0, periph_ctl});
         chk("auto_ack", {7'h0, rows[i].a[1:0] == 2'h0}, {7'h0, ack_seen});
      end
      // data lines driven only in output mode or bidir with direction high
      chk("db_oe", 8'h00, {7'h0, db_oe});
      acc(1'b1, 8'h56, 8'h0f, q);
      chk("db_oe_out", 8'h01, {7'h0, db_oe});
      acc(1'b1, 8'h56, 8'h8f, q);
      chk("db_oe_bidir", 8'h00, {7'h0, db_oe});
      // one strap bit mismatched at a time
      for (int i = 0; i < 7; i++) begin
         io_expansion_select = (i == 6);
         acc(1'b0, (i < 6) ? (8'h54 ^ (8'h04 << i)) : 8'h54, 8'h00, q);
         chk("miss_oe", 8'h00, {7'h0, oe_seen});
      end
      io_expansion_select = 1'b0;
      acc(1'b1, 8'h14, 8'h77, q);
      chk("miss_wr", 8'h5a, db_out);
      // vector and interrupt enable, then one byte from the controller
      acc(1'b1, 8'h56, 8'h20, q);
      acc(1'b1, 8'h56, 8'h87, q);
      fork
         u_dbha_periph_model.send(8'hc3, 12, ok);
         begin
            n = 0;
            while (external_ready_connector !== 1'b1 && n < 10) begin
               @(negedge clk);
               n++;
            end
            chk("ready_set", 8'h01, {7'h0, external_ready_connector});
            acc(1'b0, 8'h54, 8'h00, q);
            chk("rd_data", 8'hc3, q);
            chk("ready_clr", 8'h00, {7'h0, external_ready_connector});
            chk("ack_hold", 8'h00, {7'h0, periph_ctl.ack_n});
         end
      join
      chk("ack_seen", 8'h01, {7'h0, ok});
      repeat (6) @(negedge clk);
      chk("ack_rel", 8'h01, {7'h0, periph_ctl.ack_n});
      // request fall raised the interrupt, acknowledge returns the vector
      chk("int_req", 8'h01, {7'h0, bp_int_req});
      bp_int_ack = 1'b1;
      repeat (4) @(negedge clk);
      chk("vector", 8'h20, bp_data_out);
      chk("vec_oe", 8'h01, {7'h0, bp_data_oe});
      chk("int_clr", 8'h00, {7'h0, bp_int_req});
      bp_int_ack = 1'b0;
      repeat (4) @(negedge clk);
      chk("vec_oe_off", 8'h00, {7'h0, bp_data_oe});
      // reset in mid-run, no false request edge after it
      sys_rst = 1'b1;
      repeat (3) @(negedge clk);
      sys_rst = 1'b0;
      chk("rst_db_out", 8'h00, db_out);
      chk("rst_ctl", 8'h07, {5'h0, periph_ctl});
      repeat (4) @(negedge clk);
      chk("rst_ready", 8'h00, {7'h0, external_ready_connector});
      chk("rst_int", 8'h00, {7'h0, bp_int_req});
      auto_acknowledge_strap = 1'b0;
      acc(1'b1, 8'h54, 8'h66, q);
      chk("no_ack", 8'h00, {7'h0, ack_seen});
      chk("db_out", 8'h66, db_out);
      end_sim();
   end
endmodule : disk_bus_host_adapter_test
`default_nettype wire
